// [qpp_ports.sv]
// Quad parallel port block: ports 0..3 with AXI4-Lite register access.
// Assumes pins are asynchronous to clk_sys; peripherals share the clock.
`default_nettype none
module qpp_ports
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port0In,
  output var  logic [7:0]  port0Out,
  output var  logic [7:0]  port0Oe,
  input  wire logic [7:0]  port1In,
  output var  logic [7:0]  port1Out,
  output var  logic [7:0]  port1Oe,
  input  wire logic [2:0]  port2In,
  output var  logic [2:0]  port2Out,
  output var  logic [2:0]  port2Oe,
  input  wire logic [7:0]  port3In,
  output var  logic [7:0]  port3Out,
  output var  logic [7:0]  port3Oe,
  input  wire logic        serialAOut,
  input  wire logic        serialAClockOut,
  input  wire logic        serialAClockDrive,
  input  wire logic        uartATransmit,
  input  wire logic [7:0]  port1AltOut,
  input  wire logic [7:0]  port1AltSel,
  output var  logic        extIrqA,
  output var  logic        extIrqB,
  output var  logic        extIrqC,
  output var  logic        extIrqD,
  output var  logic        serialAIn,
  output var  logic        serialAClockIn,
  output var  logic        uartAReceive,
  output var  logic [7:0]  port1PinsToTimers,
  output var  logic        port2Bit0Fall,
  output var  logic        dualClockMode,
  output var  logic        stopMode
);

  typedef struct packed {
    logic [7:0]  p0Latch;
    logic [7:0]  p0Drive;
    logic [7:0]  p1Latch;
    logic [7:0]  p1Dir;
    logic [2:0]  p2Latch;
    logic [7:0]  p3Latch;
    logic [2:0]  ctrl;
    logic        p2FallFlag;
    logic [26:0] syncA;
    logic [26:0] syncB;
    logic        p20Prev;
    logic        awHeld;
    logic [5:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [7:0]  p0Out;
    logic [7:0]  p0Oe;
    logic [7:0]  p1Out;
    logic [7:0]  p1Oe;
    logic [2:0]  p2Out;
    logic [2:0]  p2Oe;
    logic [7:0]  p3Out;
    logic [7:0]  p3Oe;
    logic [7:0]  p0Alt;
    logic [7:0]  p1Pins;
    logic        p2Fall;
  } qpp_state_s;

  qpp_state_s state;
  qpp_state_s next_state;
  logic [7:0] pin0;
  logic [7:0] pin1;
  logic [2:0] pin2;
  logic [7:0] pin3;
  logic [7:0] p0Drv;
  logic [7:0] p1Drv;
  logic [7:0] p1ReadVal;
  logic [2:0] p2Drv;
  logic       doWrite;
  logic [5:0] rIdx;
  logic [7:0] wByte;

  // Synchronised pin levels, second stage only
  assign pin0 = state.syncB[7:0];
  assign pin1 = state.syncB[15:8];
  assign pin2 = state.syncB[18:16];
  assign pin3 = state.syncB[26:19];

  // Port0 output data: peripherals pull through the latch AND
  always_comb
  begin
    p0Drv = state.p0Latch;
    p0Drv[qpp_pkg::P0_UTX]  = state.p0Latch[qpp_pkg::P0_UTX] & uartATransmit;
    p0Drv[qpp_pkg::P0_SOUT] = state.p0Latch[qpp_pkg::P0_SOUT] & serialAOut;
    p0Drv[qpp_pkg::P0_SCLK] = state.p0Latch[qpp_pkg::P0_SCLK]
                              & (serialAClockOut | ~serialAClockDrive);
  end

  // Port1 alternate outputs replace latch where selected
  assign p1Drv = (state.p1Latch & ~port1AltSel) | (port1AltOut & port1AltSel);
  // Output bits read the latch, input bits read the pin
  assign p1ReadVal = (state.p1Latch & state.p1Dir) | (pin1 & ~state.p1Dir);

  // Dual-clock mode takes bits 1 and 2 away from the port
  assign p2Drv = state.p2Latch;

  assign doWrite = state.awHeld & state.wHeld & ~state.bValid;
  assign rIdx    = s_axi_araddr[7:2];
  assign wByte   = state.wData[7:0];

  // Whole-block next-state logic
  always_comb
  begin
    next_state = state;
    next_state.syncA = {port3In, port2In, port1In, port0In};
    next_state.syncB = state.syncA;
    next_state.p20Prev = pin2[0];

    // Write address and data taken in either order
    if (s_axi_awvalid && !state.awHeld)
    begin
      next_state.awHeld = 1'b1;
      next_state.awAddr = s_axi_awaddr[7:2]; // Byte address held as index
    end
    if (s_axi_wvalid && !state.wHeld)
    begin
      next_state.wHeld = 1'b1;
      next_state.wData = s_axi_wdata;
      next_state.wStrb = s_axi_wstrb;
    end
    if (state.bValid && s_axi_bready)
      next_state.bValid = 1'b0;

    // Register writes land the cycle after both halves are held
    if (doWrite)
    begin
      next_state.awHeld = 1'b0;
      next_state.wHeld  = 1'b0;
      next_state.bValid = 1'b1;
      next_state.bResp  = qpp_pkg::RESP_OKAY;
      if (state.wStrb[0])
      begin
        case (state.awAddr[5:0])
          qpp_pkg::IDX_P0_LATCH: next_state.p0Latch = wByte;
          qpp_pkg::IDX_P1_LATCH: next_state.p1Latch = wByte;
          qpp_pkg::IDX_P2_LATCH: next_state.p2Latch = wByte[2:0];
          qpp_pkg::IDX_P3_LATCH: next_state.p3Latch = wByte;
          qpp_pkg::IDX_P0_DRIVE: next_state.p0Drive = wByte;
          qpp_pkg::IDX_P1_DIR:   next_state.p1Dir   = wByte;
          qpp_pkg::IDX_CTRL:     next_state.ctrl    = wByte[2:0];
          // Bit-modify: input bits get pin levels written back
          qpp_pkg::IDX_P1_RMW:
          begin
            next_state.p1Latch = p1ReadVal;
            next_state.p1Latch[state.wData[2:0]] = state.wData[qpp_pkg::RMW_SET];
          end
          qpp_pkg::IDX_STATUS:
          begin
            if (wByte[qpp_pkg::STAT_P20])
              next_state.p2FallFlag = 1'b0;
          end
          qpp_pkg::IDX_P0_PINS, qpp_pkg::IDX_P2_PINS, qpp_pkg::IDX_P3_PINS:
            next_state.bResp = qpp_pkg::RESP_SLVERR;
          default: next_state.bResp = qpp_pkg::RESP_SLVERR;
        endcase
      end
    end

    // Falling edge on bit0 sets the fall flag, even when driven; set beats clear
    next_state.p2Fall = state.p20Prev & ~pin2[0];
    if (next_state.p2Fall)
      next_state.p2FallFlag = 1'b1;

    // Read channel: pins sampled at the address handshake
    if (state.rValid && s_axi_rready)
      next_state.rValid = 1'b0;
    if (s_axi_arvalid && !state.rValid)
    begin
      next_state.rValid = 1'b1;
      next_state.rResp  = qpp_pkg::RESP_OKAY;
      next_state.rData  = 32'h0000_0000;
      case (rIdx)
        qpp_pkg::IDX_P0_LATCH: next_state.rData[7:0] = state.p0Latch;
        qpp_pkg::IDX_P0_PINS:  next_state.rData[7:0] = pin0;
        qpp_pkg::IDX_P1_LATCH: next_state.rData[7:0] = p1ReadVal;
        qpp_pkg::IDX_P1_DIR:   next_state.rData[7:0] = state.p1Dir;
        qpp_pkg::IDX_P0_DRIVE: next_state.rData[7:0] = state.p0Drive;
        // Upper five bits undefined; driven zero here
        qpp_pkg::IDX_P2_LATCH: next_state.rData[2:0] = state.p2Latch;
        qpp_pkg::IDX_P2_PINS:  next_state.rData[2:0] = pin2;
        qpp_pkg::IDX_P3_LATCH: next_state.rData[7:0] = state.p3Latch;
        qpp_pkg::IDX_P3_PINS:  next_state.rData[7:0] = pin3;
        qpp_pkg::IDX_P1_RMW:   next_state.rData[7:0] = p1ReadVal;
        qpp_pkg::IDX_CTRL:     next_state.rData[2:0] = state.ctrl;
        qpp_pkg::IDX_STATUS:   next_state.rData[qpp_pkg::STAT_P20] = state.p2FallFlag;
        default:               next_state.rResp = qpp_pkg::RESP_SLVERR;
      endcase
    end

    // Port0: open-drain only drives low, push-pull drives both
    next_state.p0Out = p0Drv;
    next_state.p0Oe  = state.p0Drive | ~p0Drv;
    // Port1: direction bit enables the driver
    next_state.p1Out = p1Drv;
    next_state.p1Oe  = state.p1Dir;
    // Port2: sink-only outputs, crystal and stop overrides
    next_state.p2Out = p2Drv;
    next_state.p2Oe  = ~p2Drv & {3{state.ctrl[qpp_pkg::CTRL_OEN]}};
    if (state.ctrl[qpp_pkg::CTRL_DUAL])
      next_state.p2Oe[2:1] = 2'h0;
    if (state.ctrl[qpp_pkg::CTRL_STOP])
      next_state.p2Oe[0] = 1'b0;
    // Port3: high-current sink, pulls low only
    next_state.p3Out = state.p3Latch;
    next_state.p3Oe  = ~state.p3Latch;
    // Alternate inputs seen on pins
    next_state.p0Alt  = pin0;
    next_state.p1Pins = pin1;
  end

  // Single state register; constants only under reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state         <= '0;
      state.p0Latch <= qpp_pkg::RST_P0_LATCH;
      state.p0Drive <= qpp_pkg::RST_P0_DRIVE;
      state.p1Latch <= qpp_pkg::RST_P1_LATCH;
      state.p1Dir   <= qpp_pkg::RST_P1_DIR;
      state.p2Latch <= qpp_pkg::RST_P2_LATCH;
      state.p3Latch <= qpp_pkg::RST_P3_LATCH;
      state.p0Out   <= qpp_pkg::RST_P0_LATCH;
      state.p2Out   <= qpp_pkg::RST_P2_LATCH;
      state.p3Out   <= qpp_pkg::RST_P3_LATCH;
      state.syncA   <= '1;
      state.syncB   <= '1;
      state.p20Prev <= 1'b1;
      state.p0Alt   <= '1;
      state.p1Pins  <= '1;
    end
    else
      state <= next_state;
  end

  // Outputs straight from state
  assign s_axi_awready     = ~state.awHeld;
  assign s_axi_wready      = ~state.wHeld;
  assign s_axi_bvalid      = state.bValid;
  assign s_axi_bresp       = state.bResp;
  assign s_axi_arready     = ~state.rValid;
  assign s_axi_rvalid      = state.rValid;
  assign s_axi_rdata       = state.rData;
  assign s_axi_rresp       = state.rResp;
  assign port0Out          = state.p0Out;
  assign port0Oe           = state.p0Oe;
  assign port1Out          = state.p1Out;
  assign port1Oe           = state.p1Oe;
  assign port2Out          = state.p2Out;
  assign port2Oe           = state.p2Oe;
  assign port3Out          = state.p3Out;
  assign port3Oe           = state.p3Oe;
  assign extIrqA           = state.p0Alt[qpp_pkg::P0_IRQ_A];
  assign extIrqB           = state.p0Alt[qpp_pkg::P0_IRQ_B];
  assign extIrqC           = state.p0Alt[qpp_pkg::P0_IRQ_C];
  assign serialAIn         = state.p0Alt[qpp_pkg::P0_SIN];
  assign serialAClockIn    = state.p0Alt[qpp_pkg::P0_SCLK];
  assign uartAReceive      = state.p0Alt[qpp_pkg::P0_URX];
  assign extIrqD           = state.p1Pins[qpp_pkg::P1_IRQ_D];
  assign port1PinsToTimers = state.p1Pins;
  assign port2Bit0Fall     = state.p2Fall;
  assign dualClockMode     = state.ctrl[qpp_pkg::CTRL_DUAL];
  assign stopMode          = state.ctrl[qpp_pkg::CTRL_STOP];

endmodule
`default_nettype wire

// [qpp_pkg.sv]
// Package for the quad parallel port block: register map, reset values, bit positions.
// Assumes an AXI4-Lite master with 32-bit data; offsets are register indices (x4 for bytes).
`default_nettype none
package qpp_pkg;
  // Register indices
  localparam logic [5:0] IDX_P0_LATCH = 6'h00;
  localparam logic [5:0] IDX_P1_LATCH = 6'h01;
  localparam logic [5:0] IDX_P2_LATCH = 6'h02;
  localparam logic [5:0] IDX_P3_LATCH = 6'h03;
  localparam logic [5:0] IDX_P0_DRIVE = 6'h08;
  localparam logic [5:0] IDX_P1_DIR   = 6'h09;
  localparam logic [5:0] IDX_P0_PINS  = 6'h0B;
  localparam logic [5:0] IDX_P2_PINS  = 6'h0C;
  localparam logic [5:0] IDX_P3_PINS  = 6'h0D;
  localparam logic [5:0] IDX_P1_RMW   = 6'h10;
  localparam logic [5:0] IDX_CTRL     = 6'h11;
  localparam logic [5:0] IDX_STATUS   = 6'h12;
  // Reset values
  localparam logic [7:0] RST_P0_LATCH = 8'hFF;
  localparam logic [7:0] RST_P0_DRIVE = 8'h00;
  localparam logic [7:0] RST_P1_LATCH = 8'h00;
  localparam logic [7:0] RST_P1_DIR   = 8'h00;
  localparam logic [2:0] RST_P2_LATCH = 3'h7;
  localparam logic [7:0] RST_P3_LATCH = 8'hFF;
  // Field positions
  localparam int P0_IRQ_A  = 0;
  localparam int P0_URX    = 1;
  localparam int P0_UTX    = 2;
  localparam int P0_IRQ_B  = 3;
  localparam int P0_SIN    = 4;
  localparam int P0_SOUT   = 5;
  localparam int P0_SCLK   = 6;
  localparam int P0_IRQ_C  = 7;
  localparam int P1_DIVOUT = 1;
  localparam int P1_IRQ_D  = 5;
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_OEN  = 2;
  localparam int RMW_SET   = 8;
  localparam int STAT_P20  = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [qpp_ports_properties.sv]
// Checker for the quad parallel port block, bound to its top module.
// Assumes one clock domain and pins that change only between clock edges.
`default_nettype none
module qpp_ports_properties
(
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [7:0] port0Out,
  input wire logic [7:0] port0Oe,
  input wire logic [7:0] port1In,
  input wire logic [7:0] port1Out,
  input wire logic [7:0] port1Oe,
  input wire logic [2:0] port2In,
  input wire logic [2:0] port2Out,
  input wire logic [7:0] port3Out,
  input wire logic [7:0] port3Oe,
  input wire logic [7:0] port1PinsToTimers,
  input wire logic       port2Bit0Fall
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Reset state as seen at the first edge after release
  property p_p0_reset; $rose(reset_n) |-> port0Out == 8'hFF && port0Oe == 8'h00; endproperty
  a_p0_reset: assert property (p_p0_reset) else $error("port0 reset state");
  property p_p1_reset; $rose(reset_n) |-> port1Out == 8'h00 && port1Oe == 8'h00; endproperty
  a_p1_reset: assert property (p_p1_reset) else $error("port1 reset state");
  property p_p23_reset; $rose(reset_n) |-> port2Out == 3'h7 && port3Out == 8'hFF; endproperty
  a_p23_reset: assert property (p_p23_reset) else $error("port2 or 3 reset state");
  // Open drain only sinks, so a released bit must carry a one
  property p_p0_drain; (~port0Oe & ~port0Out) == 8'h00; endproperty
  a_p0_drain: assert property (p_p0_drain) else $error("port0 drives low unenabled");
  property p_p3_sink; port3Oe == ~port3Out; endproperty
  a_p3_sink: assert property (p_p3_sink) else $error("port3 not sink only");
  // Quiet pins must have crossed the synchroniser after four edges
  property p_sync; $stable(port1In) [*4] |-> port1PinsToTimers == port1In; endproperty
  a_sync: assert property (p_sync) else $error("port1 sync path");
  // One flag pulse per falling edge, late by the synchroniser and the pulse register
  property p_fall; $fell(port2In[0]) |-> ##[2:4] port2Bit0Fall; endproperty
  a_fall: assert property (p_fall) else $error("port2 bit0 fall missed");
  property p_fall_once; port2Bit0Fall |=> !port2Bit0Fall; endproperty
  a_fall_once: assert property (p_fall_once) else $error("fall pulse too long");
  property p_read_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  c_fall: cover property (port2Bit0Fall);
  c_read: cover property (s_axi_rvalid);
  c_dir: cover property (port1Oe == 8'h0F);
endmodule
bind qpp_ports qpp_ports_properties u_props
(
  .clk_sys, .reset_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .port0Out, .port0Oe,
  .port1In, .port1Out, .port1Oe, .port2In, .port2Out, .port3Out, .port3Oe,
  .port1PinsToTimers, .port2Bit0Fall
);
`default_nettype wire

// [qpp_pin_model.sv]
// Far side of one port: outside drivers on each pin plus a pull-up.
// Assumes enables are high where a party drives its level.
`default_nettype none
module qpp_pin_model
#(
  parameter int W = 8
)
(
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] farLevel,
  input  wire logic [W-1:0] farDrive,
  output var  logic [W-1:0] pinLevel
);
  // Wired-AND: a low from either side wins, released lines float high
  always_comb
  begin
    pinLevel = (pinOut | ~pinOe) & (farLevel | ~farDrive);
  end
endmodule
`default_nettype wire

// [test_quad_parallel_port_block.sv]
// Bench for the quad parallel port block: register tests and pin stimulus.
// Assumes package, design, pin model and checker are compiled before it.
`default_nettype none
module test_quad_parallel_port_block;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] OK  = qpp_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = qpp_pkg::RESP_SLVERR;
  logic        clk_sys       = 1'b0;
  logic        reset_n       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        uartATransmit = 1'b1;
  logic        sclkOut       = 1'b1;
  logic        sclkDrive     = 1'b0;
  logic [7:0]  altOut        = 8'h00;
  logic [7:0]  altSel        = 8'h00;
  logic [7:0]  lvl [4]       = '{default: 8'h00};
  logic [7:0]  drv [4]       = '{default: 8'h00};
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  port0In, port0Out, port0Oe, port1In, port1Out, port1Oe;
  logic [7:0]  port3In, port3Out, port3Oe;
  logic [2:0]  port2In, port2Out, port2Oe;
  logic        extIrqA, extIrqB, extIrqC, serialAIn, uartAReceive;
  logic        extIrqD, serialAClockIn, dualClockMode, stopMode;
  logic [7:0]  port1PinsToTimers;
  int          fails         = 0;
  int          checked       = 0;
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  // Serial out shares the uart strobe so both latch gates are exercised
  qpp_ports u_dut
  (
    .clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port0In, .port0Out, .port0Oe, .port1In, .port1Out,
    .port1Oe, .port2In, .port2Out, .port2Oe, .port3In, .port3Out, .port3Oe,
    .serialAOut(uartATransmit), .serialAClockOut(sclkOut), .serialAClockDrive(sclkDrive),
    .uartATransmit, .port1AltOut(altOut), .port1AltSel(altSel), .extIrqA, .extIrqB,
    .extIrqC, .extIrqD, .serialAIn, .serialAClockIn, .uartAReceive,
    .port1PinsToTimers, .port2Bit0Fall(), .dualClockMode, .stopMode
  );
  qpp_pin_model #(.W(8)) u_pin0 (.pinOut(port0Out), .pinOe(port0Oe), .farLevel(lvl[0]),
    .farDrive(drv[0]), .pinLevel(port0In));
  qpp_pin_model #(.W(8)) u_pin1 (.pinOut(port1Out), .pinOe(port1Oe), .farLevel(lvl[1]),
    .farDrive(drv[1]), .pinLevel(port1In));
  qpp_pin_model #(.W(3)) u_pin2 (.pinOut(port2Out), .pinOe(port2Oe), .farLevel(lvl[2][2:0]),
    .farDrive(drv[2][2:0]), .pinLevel(port2In));
  qpp_pin_model #(.W(8)) u_pin3 (.pinOut(port3Out), .pinOe(port3Oe), .farLevel(lvl[3]),
    .farDrive(drv[3]), .pinLevel(port3In));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write: address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rdchk(input string nm, input logic [5:0] idx, input logic [31:0] e,
                       input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(nm, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // Covers two sync edges, the output register and one spare edge
  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdchk("p0_latch", 6'h00, 32'hFF, OK);
    rdchk("p0_drive", 6'h08, 32'h00, OK);
    rdchk("p1_dir", 6'h09, 32'h00, OK);
    rdchk("p2_latch", 6'h02, 32'h07, OK);
    rdchk("p3_latch", 6'h03, 32'hFF, OK);
    $display("test reset values done");
    wr(6'h00, 8'hA5, OK);
    settle();
    chk("p0_oe_drain", 32'h5A, {24'h0, port0Oe});
    wr(6'h08, 8'hF0, OK);
    settle();
    chk("p0_oe_mixed", 32'hFA, {24'h0, port0Oe});
    chk("p0_out", 32'hA5, {24'h0, port0Out});
    wr(6'h00, 8'hFF, OK);
    wr(6'h08, 8'h00, OK);
    lvl[0] <= 8'h3C;
    drv[0] <= 8'hFF;
    settle();
    rdchk("p0_pins", 6'h0B, 32'h3C, OK);
    rdchk("p0_latch", 6'h00, 32'hFF, OK);
    chk("p0_alt_in", 32'hA,
        {26'h0, serialAClockIn, extIrqC, extIrqB, extIrqA, serialAIn, uartAReceive});
    wr(6'h0B, 8'h00, ERR);
    uartATransmit <= 1'b0;
    settle();
    chk("p0_alt_out", 32'hDB, {24'h0, port0Out});
    // Serial clock driven low by the peripheral pulls bit 6 down
    sclkOut   <= 1'b0;
    sclkDrive <= 1'b1;
    settle();
    chk("p0_sclk_out", 32'h9B, {24'h0, port0Out});
    $display("test port0 done");
    lvl[1] <= 8'hAA;
    drv[1] <= 8'hFF;
    wr(6'h01, 8'hF5, OK);
    wr(6'h09, 8'h0F, OK);
    settle();
    chk("p1_oe", 32'h0F, {24'h0, port1Oe});
    chk("p1_out", 32'h5, {28'h0, port1Out[3:0]});
    rdchk("p1_mixed", 6'h01, 32'hA5, OK);
    // Bit-modify clears bit 0; input bits pick up the pin levels
    wr(6'h10, 8'h00, OK);
    settle();
    chk("p1_rmw_latch", 32'hA4, {24'h0, port1Out});
    altOut <= 8'h02;
    altSel <= 8'h02;
    // Output register, two sync edges and the pin register need four edges; two settles give eight
    settle();
    settle();
    chk("p1_alt_out", 32'hA6, {24'h0, port1Out});
    chk("p1_to_timers", 32'h1A2, {23'h0, extIrqD, port1PinsToTimers});
    $display("test port1 done");
    wr(6'h03, 8'h0F, OK);
    settle();
    chk("p3_oe", 32'hF0, {24'h0, port3Oe});
    wr(6'h03, 8'hFF, OK);
    lvl[3] <= 8'h33;
    drv[3] <= 8'hFF;
    settle();
    rdchk("p3_pins", 6'h0D, 32'h33, OK);
    rdchk("p3_latch", 6'h03, 32'hFF, OK);
    wr(6'h0D, 8'h00, ERR);
    $display("test port3 done");
    lvl[2] <= 8'h06;
    drv[2] <= 8'h01;
    settle();
    rdchk("p2_pins", 6'h0C, 32'h6, OK);
    rdchk("p2_latch", 6'h02, 32'h7, OK);
    rdchk("p2_fall_flag", 6'h12, 32'h1, OK);
    rdchk("unmapped", 6'h3F, 32'h0, ERR);
    wr(6'h12, 8'h01, OK);
    rdchk("p2_flag_clr", 6'h12, 32'h0, OK);
    // Far side lets go; port2 then pulls its own bit 0 low
    drv[2] <= 8'h00;
    wr(6'h11, 8'h04, OK);
    wr(6'h02, 8'h00, OK);
    settle();
    chk("p2_oe", 32'h7, {29'h0, port2Oe});
    chk("p2_out", 32'h0, {29'h0, port2Out});
    rdchk("p2_own_fall", 6'h12, 32'h1, OK);
    wr(6'h11, 8'h05, OK);
    settle();
    chk("p2_dual_oe", 32'h1, {29'h0, port2Oe});
    chk("dual_mode", 32'h1, {31'h0, dualClockMode});
    wr(6'h11, 8'h06, OK);
    settle();
    chk("p2_stop_oe", 32'h6, {29'h0, port2Oe});
    chk("stop_mode", 32'h1, {31'h0, stopMode});
    wr(6'h02, 8'h07, OK);
    rdchk("p2_latch_back", 6'h02, 32'h7, OK);
    $display("test port2 done");
    print_verdict();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
